// ---- core/dsp_agc_channel_enable_regs.sv ----
/*
  page-0 control bank for volume ganging, biquad count, soft stepping,
  gain loop setup, input channel enables, output slot enables and the
  converter power bit; drives per-channel control outputs.
  assumes: the host control port has already decoded a byte write or read
  with page, address and strobes on core_clk_i; serializer supplies slots.
*/
`default_nettype none
module dsp_agc_channel_enable_regs #(
  parameter int NUM_CH = agc_regs_pkg::NUM_CH,
  parameter int VOL_W  = 8
) (
  input  wire logic                    core_clk_i,
  input  wire logic                    nrst_i,
  input  wire logic [7:0]              page_i,
  input  wire logic [7:0]              addr_i,
  input  wire logic                    wr_en_i,
  input  wire logic                    rd_en_i,
  input  wire logic [7:0]              wdata_i,
  output logic      [7:0]              rdata_o,
  output logic                         rd_hit_o,
  input  wire logic [NUM_CH*VOL_W-1:0] channel_volume_i,
  output logic      [NUM_CH*VOL_W-1:0] digital_volume_o,
  output logic      [1:0]              biquad_count_o,
  output logic                         soft_step_enable_o,
  output logic      [NUM_CH-1:0]       gain_loop_active_o,
  input  wire logic [NUM_CH-1:0]       gain_loop_channel_enable_i,
  output logic      [3:0]              gain_loop_target_o,
  output logic      [3:0]              gain_loop_ceiling_o,
  output logic                         ceiling_reserved_o,
  output logic      [NUM_CH-1:0]       channel_power_o,
  output logic      [NUM_CH-1:0]       analog_path_enable_o,
  output logic      [NUM_CH-1:0]       pdm_path_enable_o,
  input  wire logic [NUM_CH-1:0]       channel_is_pdm_i,
  input  wire logic                    slot_active_i,
  input  wire logic [2:0]              slot_index_i,
  input  wire logic                    slot_data_i,
  output logic                         sdout_o,
  output logic                         sdout_oe_o
);
  logic [7:0] sp_setup;
  logic [7:0] gain_setup;
  logic [7:0] in_enables;
  logic [7:0] slot_enables;
  logic [7:0] pwr_setup;
  logic       page_hit;
  logic       wr_sp;
  logic       wr_gain;
  logic       wr_in;
  logic       wr_slot;
  logic       wr_pwr;
  logic [7:0] next_rdata;
  logic       next_hit;
  logic [NUM_CH*VOL_W-1:0] next_volume;
  logic [NUM_CH-1:0]       next_power;
  logic [NUM_CH-1:0]       next_analog;
  logic [NUM_CH-1:0]       next_pdm;
  logic [NUM_CH-1:0]       next_gain_active;

  // page and address decode of writes
  assign page_hit = (page_i == agc_regs_pkg::PAGE_MAIN);
  assign wr_sp    = wr_en_i && page_hit && (addr_i == agc_regs_pkg::ADDR_SP_SETUP);
  assign wr_gain  = wr_en_i && page_hit && (addr_i == agc_regs_pkg::ADDR_GAIN_SETUP);
  assign wr_in    = wr_en_i && page_hit && (addr_i == agc_regs_pkg::ADDR_IN_EN);
  assign wr_slot  = wr_en_i && page_hit && (addr_i == agc_regs_pkg::ADDR_SLOT_EN);
  assign wr_pwr   = wr_en_i && page_hit && (addr_i == agc_regs_pkg::ADDR_PWR_SETUP);

  // the five storage registers
  ctrl_reg8 #(.RESET_VALUE(agc_regs_pkg::RST_SP_SETUP)) u_sp_setup (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .wr_i       (wr_sp),
    .wdata_i    (wdata_i),
    .q_o        (sp_setup)
  );

  ctrl_reg8 #(.RESET_VALUE(agc_regs_pkg::RST_GAIN_SETUP)) u_gain_setup (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .wr_i       (wr_gain),
    .wdata_i    (wdata_i),
    .q_o        (gain_setup)
  );

  ctrl_reg8 #(.RESET_VALUE(agc_regs_pkg::RST_IN_EN)) u_in_enables (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .wr_i       (wr_in),
    .wdata_i    (wdata_i),
    .q_o        (in_enables)
  );

  ctrl_reg8 #(.RESET_VALUE(agc_regs_pkg::RST_SLOT_EN)) u_slot_enables (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .wr_i       (wr_slot),
    .wdata_i    (wdata_i),
    .q_o        (slot_enables)
  );

  ctrl_reg8 #(.RESET_VALUE(agc_regs_pkg::RST_PWR_SETUP)) u_pwr_setup (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .wr_i       (wr_pwr),
    .wdata_i    (wdata_i),
    .q_o        (pwr_setup)
  );

  // read mux, unmapped addresses read zero with no hit
  always_comb begin
    next_rdata = 8'h00;
    next_hit   = 1'b0;
    if (rd_en_i && page_hit) begin
      next_hit = 1'b1;
      case (addr_i)
        agc_regs_pkg::ADDR_SP_SETUP:   next_rdata = sp_setup;
        agc_regs_pkg::ADDR_GAIN_SETUP: next_rdata = gain_setup;
        agc_regs_pkg::ADDR_IN_EN:      next_rdata = in_enables;
        agc_regs_pkg::ADDR_SLOT_EN:    next_rdata = slot_enables;
        agc_regs_pkg::ADDR_PWR_SETUP:  next_rdata = pwr_setup;
        default:                       next_hit   = 1'b0;
      endcase
    end
  end

  // per-channel volume, power and path selection
  always_comb begin
    next_volume      = '0;
    next_power       = '0;
    next_analog      = '0;
    next_pdm         = '0;
    next_gain_active = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      // channel c+1 lives at enable bit NUM_CH-1-c
      if (sp_setup[agc_regs_pkg::GANG_BIT]) begin
        next_volume[c*VOL_W +: VOL_W] = channel_volume_i[0 +: VOL_W];
      end else begin
        next_volume[c*VOL_W +: VOL_W] = channel_volume_i[c*VOL_W +: VOL_W];
      end
      next_power[c] = pwr_setup[agc_regs_pkg::CONV_PWR_BIT] &&
                      in_enables[NUM_CH-1-c];
      if (c >= NUM_CH - agc_regs_pkg::NUM_PDM_ONLY) begin
        next_pdm[c] = next_power[c];
      end else begin
        next_pdm[c]    = next_power[c] && channel_is_pdm_i[c];
        next_analog[c] = next_power[c] && !channel_is_pdm_i[c];
      end
      next_gain_active[c] = sp_setup[agc_regs_pkg::GAIN_SEL_BIT] &&
                            gain_loop_channel_enable_i[c] && next_power[c];
    end
  end

  // registered outputs
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o              <= 8'h00;
      rd_hit_o             <= 1'b0;
      digital_volume_o     <= '0;
      channel_power_o      <= '0;
      analog_path_enable_o <= '0;
      pdm_path_enable_o    <= '0;
      gain_loop_active_o   <= '0;
    end else begin
      rdata_o              <= next_rdata;
      rd_hit_o             <= next_hit;
      digital_volume_o     <= next_volume;
      channel_power_o      <= next_power;
      analog_path_enable_o <= next_analog;
      pdm_path_enable_o    <= next_pdm;
      gain_loop_active_o   <= next_gain_active;
    end
  end

  // field outputs taken straight from the stored registers
  assign biquad_count_o      = sp_setup[agc_regs_pkg::BIQ_HI:agc_regs_pkg::BIQ_LO];
  assign soft_step_enable_o  = !sp_setup[agc_regs_pkg::SOFTSTEP_OFF_BIT];
  assign gain_loop_target_o  = gain_setup[agc_regs_pkg::TGT_HI:agc_regs_pkg::TGT_LO];
  assign gain_loop_ceiling_o = gain_setup[agc_regs_pkg::CEIL_HI:agc_regs_pkg::CEIL_LO];
  // flag reserved ceiling codes, behaviour then undefined
  assign ceiling_reserved_o  = (gain_loop_ceiling_o > agc_regs_pkg::CEIL_MAX_LEGAL);

  // serial output slot gating
  slot_drive_gate #(.NUM_CH(NUM_CH)) u_slot_gate (
    .core_clk_i     (core_clk_i),
    .nrst_i         (nrst_i),
    .slot_enables_i (slot_enables[NUM_CH-1:0]),
    .slot_active_i  (slot_active_i),
    .slot_index_i   (slot_index_i),
    .slot_data_i    (slot_data_i),
    .sdout_o        (sdout_o),
    .sdout_oe_o     (sdout_oe_o)
  );
endmodule : dsp_agc_channel_enable_regs
`default_nettype wire

// ---- core/agc_regs_pkg.sv ----
/*
  constants for the channel and gain-loop control bank: page-0 offsets,
  field positions, reset values and codes.
  assumes: an 8-bit register port with a page number beside the address.
*/
`default_nettype none
package agc_regs_pkg;
  localparam int          NUM_CH           = 8;
  localparam int          NUM_PDM_ONLY     = 4;
  localparam logic [7:0]  PAGE_MAIN        = 8'h00;
  localparam logic [7:0]  ADDR_SP_SETUP    = 8'h6C;
  localparam logic [7:0]  ADDR_GAIN_SETUP  = 8'h70;
  localparam logic [7:0]  ADDR_IN_EN       = 8'h73;
  localparam logic [7:0]  ADDR_SLOT_EN     = 8'h74;
  localparam logic [7:0]  ADDR_PWR_SETUP   = 8'h75;
  localparam logic [7:0]  RST_SP_SETUP     = 8'h40;
  localparam logic [7:0]  RST_GAIN_SETUP   = 8'hE7;
  localparam logic [7:0]  RST_IN_EN        = 8'hF0;
  localparam logic [7:0]  RST_SLOT_EN      = 8'h00;
  localparam logic [7:0]  RST_PWR_SETUP    = 8'h00;
  // signal_processing_setup fields
  localparam int          GANG_BIT         = 7;
  localparam int          BIQ_HI           = 6;
  localparam int          BIQ_LO           = 5;
  localparam int          SOFTSTEP_OFF_BIT = 4;
  localparam int          GAIN_SEL_BIT     = 3;
  // gain_control_setup fields
  localparam int          TGT_HI           = 7;
  localparam int          TGT_LO           = 4;
  localparam int          CEIL_HI          = 3;
  localparam int          CEIL_LO          = 0;
  localparam logic [3:0]  CEIL_MAX_LEGAL   = 4'hD;
  // power_setup fields
  localparam int          CONV_PWR_BIT     = 6;
endpackage : agc_regs_pkg
`default_nettype wire

// ---- core/ctrl_reg8.sv ----
/*
  one byte-wide control register with a write strobe and a reset value.
  assumes: strobe and data come from logic on the same clock.
*/
`default_nettype none
module ctrl_reg8 #(
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  input  wire logic       core_clk_i,
  input  wire logic       nrst_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] q_o
);
  logic [7:0] next_q;

  // hold unless written
  always_comb begin
    next_q = wr_i ? wdata_i : q_o;
  end

  // register the value
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q_o <= RESET_VALUE;
    end else begin
      q_o <= next_q;
    end
  end
endmodule : ctrl_reg8
`default_nettype wire

// ---- core/slot_drive_gate.sv ----
/*
  per-slot output drive gate for the audio serial output.
  assumes: slot index and data come from the serializer on the same clock.
*/
`default_nettype none
module slot_drive_gate #(
  parameter int NUM_CH = 8
) (
  input  wire logic              core_clk_i,
  input  wire logic              nrst_i,
  input  wire logic [NUM_CH-1:0] slot_enables_i,
  input  wire logic              slot_active_i,
  input  wire logic [2:0]        slot_index_i,
  input  wire logic              slot_data_i,
  output logic                   sdout_o,
  output logic                   sdout_oe_o
);
  logic [NUM_CH-1:0] onehot;
  logic              next_oe;
  logic              next_data;

  // one-hot slot decode, bit 7 is channel one
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_slot
      assign onehot[g] = slot_active_i &&
                         (slot_index_i == 3'(NUM_CH - 1 - g)) && slot_enables_i[g];
    end
  endgenerate

  // drive only in enabled slots, otherwise high impedance
  always_comb begin
    next_oe   = |onehot;
    next_data = next_oe ? slot_data_i : 1'b0;
  end

  // registered pin drive
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sdout_o    <= 1'b0;
      sdout_oe_o <= 1'b0;
    end else begin
      sdout_o    <= next_data;
      sdout_oe_o <= next_oe;
    end
  end
endmodule : slot_drive_gate
`default_nettype wire

// ---- verification/dsp_agc_channel_enable_regs_props.sv ----
/* checker for the channel and gain-loop control bank ports.
   assumes: bound to the bank top; one clock, async low reset. */
`default_nettype none
module dsp_agc_props #(
  parameter int NUM_CH = 8
) (
  input wire logic              core_clk_i,
  input wire logic              nrst_i,
  input wire logic [7:0]        page_i,
  input wire logic [7:0]        addr_i,
  input wire logic              wr_en_i,
  input wire logic              rd_en_i,
  input wire logic [7:0]        wdata_i,
  input wire logic [7:0]        rdata_o,
  input wire logic              rd_hit_o,
  input wire logic [1:0]        biquad_count_o,
  input wire logic              soft_step_enable_o,
  input wire logic [3:0]        gain_loop_target_o,
  input wire logic [3:0]        gain_loop_ceiling_o,
  input wire logic [NUM_CH-1:0] channel_power_o,
  input wire logic [NUM_CH-1:0] analog_path_enable_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  // page-0 write strobes for registers 6C, 70 and 75
  wire w6c = wr_en_i && page_i == 8'h00 && addr_i == 8'h6C;
  wire w70 = wr_en_i && page_i == 8'h00 && addr_i == 8'h70;
  wire w75 = wr_en_i && page_i == 8'h00 && addr_i == 8'h75;
  // decode and read path
  rd_hit_a: assert property (rd_en_i && page_i == 8'h00 && addr_i == 8'h6C |=> rd_hit_o)
    else $error("mapped read gave no hit");
  rd_miss_a: assert property (rd_en_i && page_i != 8'h00 |=> !rd_hit_o && rdata_o == 8'h00)
    else $error("off-page read answered");
  rd_back_a: assert property (w75 ##1 rd_en_i && !wr_en_i && page_i == 8'h00
    && $stable(addr_i) |=> rdata_o == $past(wdata_i, 2)) else $error("readback differs");
  // field outputs follow the stored bytes
  biq_count_a: assert property (w6c |=> biquad_count_o == $past(wdata_i[6:5]))
    else $error("biquad count wrong");
  soft_step_a: assert property (w6c |=> soft_step_enable_o == !$past(wdata_i[4]))
    else $error("soft step wrong");
  gain_setup_a: assert property (w70 |=>
    {gain_loop_target_o, gain_loop_ceiling_o} == $past(wdata_i)) else $error("gain setup wrong");
  // channel power and source paths
  pdm_only_a: assert property (analog_path_enable_o[7:4] == 4'h0)
    else $error("analog path on a pdm-only channel");
  pwr_down_a: assert property (w75 && !wdata_i[6] |=> ##1 channel_power_o == '0)
    else $error("channels stay powered");
  // main scenarios reached
  cover property (rd_hit_o);
  cover property (channel_power_o != '0);
  cover property (w70);
endmodule // dsp_agc_props
bind dsp_agc_channel_enable_regs dsp_agc_props #(.NUM_CH(NUM_CH)) props_u (.*);
`default_nettype wire

// ---- verification/dsp_agc_channel_enable_regs_tb.sv ----
/* self-checking bench for the channel and gain-loop control bank.
   assumes: design and checker compiled first; bench drives all ports. */
`default_nettype none
module dsp_agc_channel_enable_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk_i, nrst_i, wr_en_i, rd_en_i, rd_hit_o, soft_step_enable_o;
  logic        ceiling_reserved_o, slot_active_i, slot_data_i, sdout_o, sdout_oe_o;
  logic [7:0]  page_i, addr_i, wdata_i, rdata_o, channel_is_pdm_i, gain_loop_channel_enable_i;
  logic [7:0]  gain_loop_active_o, channel_power_o, analog_path_enable_o, pdm_path_enable_o;
  logic [2:0]  slot_index_i;
  logic [1:0]  biquad_count_o;
  logic [3:0]  gain_loop_target_o, gain_loop_ceiling_o;
  logic [63:0] channel_volume_i, digital_volume_o;
  int          error_cnt, num_checks, cyc;
  dsp_agc_channel_enable_regs dut_u (.*);
  // clock
  initial begin
    core_clk_i = 1'h0;
    forever #20 core_clk_i = ~core_clk_i;
  end
  // compare and count
  task automatic chk(string n, logic [63:0] s, logic [63:0] e);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  // host byte write and read
  task automatic wr(logic [7:0] a, logic [7:0] d);
    addr_i = a;
    wdata_i = d;
    wr_en_i = 1'h1;
    tick(1);
    wr_en_i = 1'h0;
    tick(1);
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e, logic h);
    addr_i = a;
    rd_en_i = 1'h1;
    tick(1);
    chk("rdata", rdata_o, e);
    chk("hit", rd_hit_o, h);
    rd_en_i = 1'h0;
    tick(1);
  endtask
  task automatic t_reset();
    rd(8'h6C, 8'h40, 1'h1);
    rd(8'h70, 8'hE7, 1'h1);
    rd(8'h73, 8'hF0, 1'h1);
    rd(8'h74, 8'h00, 1'h1);
    rd(8'h75, 8'h00, 1'h1);
    chk("biquad", biquad_count_o, 2'h2);
    chk("soft", soft_step_enable_o, 1'h1);
    chk("gain act", gain_loop_active_o, 8'h00);
    chk("target", gain_loop_target_o, 4'hE);
    chk("ceiling", gain_loop_ceiling_o, 4'h7);
    $display("reset test done");
  endtask
  task automatic t_map();
    // write then read back to back, unmapped address and other page ignored
    addr_i = 8'h75;
    wdata_i = 8'h2C;
    wr_en_i = 1'h1;
    tick(1);
    wr_en_i = 1'h0;
    rd_en_i = 1'h1;
    tick(1);
    chk("rdata", rdata_o, 8'h2C);
    chk("hit", rd_hit_o, 1'h1);
    rd_en_i = 1'h0;
    tick(1);
    wr(8'h71, 8'hFF);
    rd(8'h71, 8'h00, 1'h0);
    page_i = 8'h01;
    wr(8'h75, 8'hFF);
    rd(8'h75, 8'h00, 1'h0);
    page_i = 8'h00;
    rd(8'h75, 8'h2C, 1'h1);
    wr(8'h75, 8'h00);
    $display("map test done");
  endtask
  task automatic t_fields();
    for (int i = 0; i < 4; i++) begin
      wr(8'h6C, 8'(i << 5));
      chk("biquad", biquad_count_o, i[1:0]);
    end
    wr(8'h6C, 8'h10);
    chk("soft", soft_step_enable_o, 1'h0);
    wr(8'h70, 8'h0D);
    tick(1);
    chk("target", gain_loop_target_o, 4'h0);
    chk("rsv", ceiling_reserved_o, 1'h0);
    wr(8'h70, 8'hFE);
    tick(1);
    chk("ceiling", gain_loop_ceiling_o, 4'hE);
    chk("rsv", ceiling_reserved_o, 1'h1);
    $display("field test done");
  endtask
  task automatic t_power();
    channel_is_pdm_i = 8'h02;
    wr(8'h73, 8'hC1);
    wr(8'h75, 8'h40);
    wr(8'h6C, 8'h08);
    tick(2);
    chk("power", channel_power_o, 8'h83);
    chk("analog", analog_path_enable_o, 8'h01);
    chk("pdm", pdm_path_enable_o, 8'h82);
    chk("gain act", gain_loop_active_o, 8'h83);
    gain_loop_channel_enable_i = 8'h02;
    tick(1);
    chk("gain act", gain_loop_active_o, 8'h02);
    gain_loop_channel_enable_i = 8'hFF;
    wr(8'h6C, 8'h00);
    wr(8'h75, 8'h00);
    tick(2);
    chk("power", channel_power_o, 8'h00);
    chk("gain act", gain_loop_active_o, 8'h00);
    $display("power test done");
  endtask
  task automatic t_gang();
    channel_volume_i = 64'h8877665544332211;
    wr(8'h6C, 8'h80);
    tick(2);
    chk("gang", digital_volume_o, {8{8'h11}});
    wr(8'h6C, 8'h00);
    tick(2);
    chk("own", digital_volume_o, 64'h8877665544332211);
    $display("gang test done");
  endtask
  task automatic t_slots();
    logic [7:0] en;
    slot_active_i = 1'h1;
    slot_data_i = 1'h1;
    for (int k = 0; k < 2; k++) begin
      en = k ? 8'h01 : 8'h80;
      wr(8'h74, en);
      for (int i = 0; i < 8; i++) begin
        slot_index_i = i[2:0];
        tick(1);
        chk("oe", sdout_oe_o, en[7-i]);
        chk("data", sdout_oe_o && sdout_o, en[7-i]);
      end
    end
    slot_active_i = 1'h0;
    $display("slot test done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // hang guard
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  // main sequence
  initial begin
    {nrst_i, wr_en_i, rd_en_i, slot_active_i, slot_data_i} = 5'h00;
    {page_i, addr_i, wdata_i, channel_is_pdm_i, slot_index_i} = 35'h0;
    gain_loop_channel_enable_i = 8'hFF;
    channel_volume_i = 64'h0;
    repeat (12) @(posedge core_clk_i);
    #1 nrst_i = 1'h1;
    t_reset();
    t_map();
    t_fields();
    t_power();
    t_gang();
    t_slots();
    report_and_stop();
  end
endmodule // dsp_agc_channel_enable_regs_tb
`default_nettype wire
